// ==== hw/reclose_forced_trip.sv ====
// forced three-pole trip, dead-line check and adaptive dead time logic with AXI4-Lite registers
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
module reclose_forced_trip #(
    parameter int DEADLINE_CYCLES = reclose_pkg::DEADLINE_CYCLES,
    parameter int CONFIRM_CYCLES  = reclose_pkg::CONFIRM_CYCLES,
    parameter int CLOSE_CYCLES    = reclose_pkg::CLOSE_CYCLES
) (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    // AXI4-Lite slave
    input  wire logic [7:0]                   s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [7:0]                   s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    // protection and plant side
    input  wire reclose_pkg::trip_req_type    tripReq,
    input  wire logic [2:0]                   ext_pole_trip_to_reclose,
    input  wire reclose_pkg::breaker_aux_type breakerAux,
    input  wire logic                         recloseBlock,
    input  wire logic                         finalTrip,
    input  wire logic                         lineVoltage,
    output logic [2:0]                        tripPole,
    output logic                              tripThreePole,
    output logic                              closeCmd
);

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic multiPhase(input logic [2:0] p);
        multiPhase = (p[0] & p[1]) | (p[1] & p[2]) | (p[0] & p[2]);
    endfunction

    function automatic logic [31:0] wordMerge(input logic [31:0] old, input logic [31:0] val,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
                r[i*8 +: 8] = val[i*8 +: 8];
        end
        wordMerge = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // registers and state

    logic [reclose_pkg::CTRL_WIDTH-1:0] ctrl;
    logic [31:0]                        deadTime;
    reclose_pkg::reclose_state_type     state;
    reclose_pkg::reclose_state_type     next_state;
    logic [31:0]                        timer;
    logic [31:0]                        next_timer;
    logic                               singlePole;
    logic                               issued3p;
    logic                               forcedTrip;
    logic                               deadLineBlock;

    // AXI state
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;

    ////////////////////////////////////////////////////////////////////////////////
    // trip combiner

    wire        recloseEn   = ctrl[reclose_pkg::CTRL_RECLOSE_EN];
    wire        forcedEn    = ctrl[reclose_pkg::CTRL_FORCED3P_EN];
    wire        deadLineEn  = ctrl[reclose_pkg::CTRL_DEADLINE_EN];
    wire        adaptiveEnd = ctrl[reclose_pkg::CTRL_ADAPTIVE];
    wire        only3p      = ctrl[reclose_pkg::CTRL_ONLY3P];

    // external reclose-bound trips stay out of this OR on purpose
    wire [2:0]  combined    = tripReq.internalTrip | tripReq.directTrip
                            | tripReq.remoteTrip;
    wire        combiner3p  = multiPhase(combined);
    wire        anyTrip     = |combined;
    wire        extTrip     = |ext_pole_trip_to_reclose;
    wire        faultStart  = anyTrip | extTrip;

    // contacts agreeing on a pole (both open or both closed) are implausible
    wire [2:0]  auxBad      = ~(breakerAux.poleOpen ^ breakerAux.poleClosed);
    wire        implausible = |auxBad;
    wire        someOpen    = |breakerAux.poleOpen;
    wire        allOpen     = &breakerAux.poleOpen;
    wire        allClosed   = &breakerAux.poleClosed;
    wire        partialOpen = someOpen & ~allOpen;

    ////////////////////////////////////////////////////////////////////////////////
    // reclose sequencing

    wire inDead   = (state == reclose_pkg::ST_DEAD);
    wire inAdapt  = (state == reclose_pkg::ST_ADAPT);
    wire deadOpen = inDead | inAdapt;

    // voltage on the line after the measuring window means no dead line
    wire dlFail   = inDead & deadLineEn & ~adaptiveEnd & lineVoltage
                  & (timer >= 32'(DEADLINE_CYCLES));
    wire blockEvt = deadOpen & (recloseBlock | finalTrip | dlFail);

    // adaptive end: only a steady voltage for the whole window counts
    wire confirmed = inAdapt & lineVoltage & (timer >= 32'(CONFIRM_CYCLES) - 32'h1);
    wire deadDone  = inDead & ~anyTrip & ~extTrip & (timer >= deadTime);

    always_comb
    begin
        next_state = state;
        next_timer = timer + 32'h1;
        case (state)
            reclose_pkg::ST_IDLE:
            begin
                next_timer = 32'h0;
                if (recloseEn & faultStart)
                    next_state = adaptiveEnd ? reclose_pkg::ST_ADAPT : reclose_pkg::ST_DEAD;
            end
            reclose_pkg::ST_DEAD:
            begin
                if (blockEvt)
                    next_state = reclose_pkg::ST_LOCKOUT;
                else if (deadDone)
                begin
                    next_state = reclose_pkg::ST_CLOSE;
                    next_timer = 32'h0;
                end
                else if (faultStart & ~(deadLineEn & (timer >= 32'(DEADLINE_CYCLES))))
                    next_timer = 32'h0;   // dead time runs from trip drop-off
            end
            reclose_pkg::ST_ADAPT:
            begin
                if (blockEvt)
                    next_state = reclose_pkg::ST_LOCKOUT;
                else if (confirmed)
                begin
                    next_state = reclose_pkg::ST_CLOSE;
                    next_timer = 32'h0;
                end
                else if (~lineVoltage)
                    next_timer = 32'h0;   // remote attempt failed, wait for the next one
            end
            reclose_pkg::ST_CLOSE:
            begin
                if (allClosed | (timer >= 32'(CLOSE_CYCLES) - 32'h1))
                    next_state = reclose_pkg::ST_IDLE;
            end
            reclose_pkg::ST_LOCKOUT:
            begin
                next_timer = 32'h0;
                if (~faultStart & ~recloseBlock & ~finalTrip & (allOpen | allClosed))
                    next_state = reclose_pkg::ST_IDLE;
            end
            default:
            begin
                next_state = reclose_pkg::ST_IDLE;
                next_timer = 32'h0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // forced three-pole trip

    wire forceBlocked = blockEvt & singlePole & ~issued3p;
    wire force3pOnly  = only3p & partialOpen;
    // every cause is gated by the setting, nothing else sets the flag
    wire forceSet     = forcedEn & (forceBlocked | implausible | force3pOnly);
    // held until the breaker is fully open; a new cause in that cycle wins
    wire forceClr     = allOpen & ~implausible;
    wire trip3pNow    = combiner3p | forcedTrip | forceSet;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state         <= reclose_pkg::ST_IDLE;
            timer         <= 32'h0;
            singlePole    <= 1'b0;
            issued3p      <= 1'b0;
            forcedTrip    <= 1'b0;
            deadLineBlock <= 1'b0;
            tripPole      <= 3'h0;
            tripThreePole <= 1'b0;
            closeCmd      <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            timer         <= next_timer;
            if (state == reclose_pkg::ST_IDLE)
            begin
                singlePole <= faultStart & ~combiner3p;
                issued3p   <= combiner3p;
            end
            else if (combiner3p | forcedTrip)
            begin
                singlePole <= 1'b0;
                issued3p   <= 1'b1;
            end
            forcedTrip    <= forceSet | (forcedTrip & ~forceClr);
            deadLineBlock <= dlFail | (deadLineBlock & ~(next_state == reclose_pkg::ST_IDLE));
            tripPole      <= trip3pNow ? 3'h7 : combined;
            tripThreePole <= trip3pNow;
            closeCmd      <= (next_state == reclose_pkg::ST_CLOSE) & ~trip3pNow & ~anyTrip;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave: write address and data taken in either order, one response

    wire        awTake  = s_axi_awvalid & s_axi_awready;
    wire        wTake   = s_axi_wvalid & s_axi_wready;
    wire        awHave  = awHeld | awTake;
    wire        wHave   = wHeld | wTake;
    wire        doWrite = awHave & wHave & ~s_axi_bvalid;
    wire [7:0]  wAddr   = awHeld ? awAddr : s_axi_awaddr;
    wire [31:0] wVal    = wHeld ? wData : s_axi_wdata;
    wire [3:0]  wBytes  = wHeld ? wStrb : s_axi_wstrb;
    wire        wrCtrl  = doWrite & (wAddr == reclose_pkg::CTRL_ADDR);
    wire        wrDead  = doWrite & (wAddr == reclose_pkg::DEADTIME_ADDR);
    // status is read-only, so a write there is refused like an unmapped one
    wire        wrOk    = wrCtrl | wrDead;

    wire [31:0] ctrlMerged = wordMerge({{(32-reclose_pkg::CTRL_WIDTH){1'b0}}, ctrl}, wVal, wBytes);
    wire [31:0] statusWord;
    assign statusWord = {
        20'h0,
        breakerAux.poleOpen,
        closeCmd,
        deadLineBlock,
        forcedTrip,
        tripThreePole,
        state
    };

    wire        arTake  = s_axi_arvalid & s_axi_arready;
    wire        rdCtrl  = (s_axi_araddr == reclose_pkg::CTRL_ADDR);
    wire        rdDead  = (s_axi_araddr == reclose_pkg::DEADTIME_ADDR);
    wire        rdStat  = (s_axi_araddr == reclose_pkg::STATUS_ADDR);
    wire [31:0] rdWord  = rdCtrl ? {{(32-reclose_pkg::CTRL_WIDTH){1'b0}}, ctrl}
                        : rdDead ? deadTime
                        : rdStat ? statusWord : 32'h0;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ctrl          <= reclose_pkg::CTRL_RESET;
            deadTime      <= reclose_pkg::DEADTIME_RESET;
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= 8'h00;
            wData         <= 32'h0;
            wStrb         <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= reclose_pkg::RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= reclose_pkg::RESP_OKAY;
        end
        else
        begin
            if (awTake)
                awAddr <= s_axi_awaddr;
            if (wTake)
            begin
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            awHeld        <= awHave & ~doWrite;
            wHeld         <= wHave & ~doWrite;
            // one channel beat each, then wait for the response to be taken
            s_axi_awready <= ~awHave & ~s_axi_bvalid & ~s_axi_awready;
            s_axi_wready  <= ~wHave & ~s_axi_bvalid & ~s_axi_wready;
            if (wrCtrl)
                ctrl <= ctrlMerged[reclose_pkg::CTRL_WIDTH-1:0];
            if (wrDead)
                deadTime <= wordMerge(deadTime, wVal, wBytes);
            if (doWrite)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrOk ? reclose_pkg::RESP_OKAY : reclose_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;

            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (arTake)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdWord;
                s_axi_rresp  <= (rdCtrl | rdDead | rdStat) ? reclose_pkg::RESP_OKAY
                                                           : reclose_pkg::RESP_SLVERR;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ==== include/reclose_pkg.sv ====
// constants, register map and carrier types for the forced-trip / adaptive dead time block
package reclose_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register map (byte addresses, one 32-bit word each)
    localparam logic [7:0] CTRL_ADDR     = 8'h00;
    localparam logic [7:0] DEADTIME_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR   = 8'h08;

    // control register fields
    localparam int CTRL_RECLOSE_EN  = 0;
    localparam int CTRL_FORCED3P_EN = 1;
    localparam int CTRL_DEADLINE_EN = 2;
    localparam int CTRL_ADAPTIVE    = 3;
    localparam int CTRL_ONLY3P      = 4;
    localparam int CTRL_WIDTH       = 5;
    localparam logic [4:0]  CTRL_RESET     = 5'h00;
    localparam logic [31:0] DEADTIME_RESET = 32'h0000_0400;

    // status register fields
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_TRIP3P    = 5;
    localparam int STAT_FORCED    = 6;
    localparam int STAT_DLBLOCK   = 7;
    localparam int STAT_CLOSE     = 8;
    localparam int STAT_POLE_LSB  = 9;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_MHZ          = 100;
    localparam int DEADLINE_MEAS_MS = 20;
    localparam int CONFIRM_MS       = 100;
    localparam int CLOSE_HOLD_MS    = 100;
    localparam int CYCLES_PER_MS    = CLK_MHZ * 1000;
    localparam int DEADLINE_CYCLES  = DEADLINE_MEAS_MS * CYCLES_PER_MS;
    localparam int CONFIRM_CYCLES   = CONFIRM_MS * CYCLES_PER_MS;
    localparam int CLOSE_CYCLES     = CLOSE_HOLD_MS * CYCLES_PER_MS;

    ////////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [2:0] internalTrip;
        logic [2:0] directTrip;
        logic [2:0] remoteTrip;
    } trip_req_type;

    typedef struct packed {
        logic [2:0] poleOpen;
        logic [2:0] poleClosed;
    } breaker_aux_type;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_DEAD    = 5'h02,
        ST_ADAPT   = 5'h04,
        ST_CLOSE   = 5'h08,
        ST_LOCKOUT = 5'h10
    } reclose_state_type;

endpackage

// ==== tb/breaker_model.sv ====
// three-pole breaker with auxiliary contacts, tripped by the block or by outside protection
module breaker_model (
    input  wire logic                         clk,
    input  wire logic                         rst_n,
    input  wire logic [2:0]                   tripPole,
    input  wire logic [2:0]                   extTrip,
    input  wire logic                         closeCmd,
    input  wire logic                         manClose,
    input  wire logic                         slow,
    input  wire logic                         auxFault,
    output reclose_pkg::breaker_aux_type      aux
);
    logic [2:0] closed;
    logic       tick;
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            closed <= 3'h7;
            tick <= 1'b0;
        end
        else
        begin
            tick <= ~tick;
            // trip wins over close, as a real mechanism would
            if (!slow || tick)
                closed <= (closed | {3{closeCmd | manClose}}) & ~(tripPole | extTrip);
        end
    end
    // a stuck contact on the first pole reads open and closed alike
    always_comb
    begin
        aux.poleClosed = closed;
        aux.poleOpen = ~closed ^ {2'h0, auxFault};
    end
endmodule

// ==== tb/reclose_chk.sv ====
// port checker for the forced-trip and adaptive dead time block
module reclose_chk #(
    parameter int DEADLINE_CYCLES = 20,
    parameter int CONFIRM_CYCLES  = 10,
    parameter int CLOSE_CYCLES    = 10
) (
    input wire logic                         clk,
    input wire logic                         rst_n,
    input wire logic [7:0]                   s_axi_awaddr,
    input wire logic                         s_axi_awvalid,
    input wire logic                         s_axi_awready,
    input wire logic [31:0]                  s_axi_wdata,
    input wire logic                         s_axi_wvalid,
    input wire logic                         s_axi_wready,
    input wire logic [1:0]                   s_axi_bresp,
    input wire logic                         s_axi_bvalid,
    input wire logic                         s_axi_bready,
    input wire reclose_pkg::trip_req_type    tripReq,
    input wire reclose_pkg::breaker_aux_type breakerAux,
    input wire logic                         lineVoltage,
    input wire logic [2:0]                   tripPole,
    input wire logic                         tripThreePole,
    input wire logic                         closeCmd
);
    logic [7:0] wa;
    logic [4:0] wd;
    logic [4:0] ctl;
    int         run;
    wire [2:0]  comb = tripReq.internalTrip | tripReq.directTrip | tripReq.remoteTrip;
    wire        fz = ctl[reclose_pkg::CTRL_FORCED3P_EN];
    wire        ad = ctl[reclose_pkg::CTRL_ADAPTIVE];
    wire        dl = ctl[reclose_pkg::CTRL_DEADLINE_EN];
    wire        o3 = ctl[reclose_pkg::CTRL_ONLY3P];
    wire [2:0]  odd = breakerAux.poleOpen ~^ breakerAux.poleClosed;
    ////////////////////////////////////////
    // shadow of the control word: it lags the real one, so settings are changed calmly
    always_ff @(posedge clk)
    begin
        if (s_axi_awvalid && s_axi_awready)
            wa <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
            wd <= s_axi_wdata[4:0];
        if (!rst_n)
            ctl <= 5'h00;
        else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0 && wa == 8'h00)
            ctl <= wd;
        run <= lineVoltage ? run + 1 : 0;
    end
    ////////////////////////////////////////
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    a_multi_phase: assert property (
        $countones(comb) > 1 |=> tripThreePole && tripPole == 3'h7)
        else $error("multi-phase request not tripped three-pole");
    a_pole_follow: assert property (
        comb != 3'h0 |=> (tripPole & $past(comb)) == $past(comb))
        else $error("requested pole not tripped");
    a_three_all: assert property (
        tripThreePole |-> tripPole == 3'h7)
        else $error("three-pole trip misses a pole");
    a_aux_implausible: assert property (
        fz && odd != 3'h0 |=> tripThreePole)
        else $error("implausible breaker not tripped");
    a_only_three: assert property (
        fz && o3 && breakerAux.poleOpen != 3'h0 && breakerAux.poleOpen != 3'h7 |=> tripThreePole)
        else $error("single open pole not forced three-pole");
    a_no_forced: assert property (
        !fz && comb == 3'h0 |=> !tripThreePole)
        else $error("three-pole trip with forced trip off");
    a_close_volt: assert property (
        ad && $rose(closeCmd) |-> run >= CONFIRM_CYCLES - 1)
        else $error("adaptive close without confirmed voltage");
    a_dead_line: assert property (
        dl && !ad && $rose(closeCmd) |-> !$past(lineVoltage, 2))
        else $error("close with voltage on a dead line");
    c_close: cover property ($rose(closeCmd));
    c_forced: cover property (fz && $rose(tripThreePole));
    c_adapt: cover property (ad && lineVoltage && !closeCmd);
endmodule
bind reclose_forced_trip reclose_chk #(
    .DEADLINE_CYCLES(DEADLINE_CYCLES), .CONFIRM_CYCLES(CONFIRM_CYCLES),
    .CLOSE_CYCLES(CLOSE_CYCLES)
) u_chk (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .tripReq(tripReq), .breakerAux(breakerAux),
    .lineVoltage(lineVoltage), .tripPole(tripPole), .tripThreePole(tripThreePole),
    .closeCmd(closeCmd)
);

// ==== tb/tb_reclose_forced_trip.sv ====
// self-checking bench for the forced-trip and adaptive dead time block
module tb_reclose_forced_trip;
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic [1:0]  bresp, rresp;
    logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, tripThreePole, closeCmd;
    logic        recloseBlock, finalTrip, lineVoltage, manClose, slow, auxFault;
    logic [2:0]  ext, tripPole;
    reclose_pkg::trip_req_type    tripReq;
    reclose_pkg::breaker_aux_type aux;
    int          num_errors, n_compared, c;
    reclose_forced_trip #(.DEADLINE_CYCLES(20), .CONFIRM_CYCLES(10), .CLOSE_CYCLES(10)) u_dut (
        .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .tripReq(tripReq), .ext_pole_trip_to_reclose(ext), .breakerAux(aux),
        .recloseBlock(recloseBlock), .finalTrip(finalTrip), .lineVoltage(lineVoltage),
        .tripPole(tripPole), .tripThreePole(tripThreePole), .closeCmd(closeCmd));
    breaker_model u_cb (.clk(clk), .rst_n(rst_n), .tripPole(tripPole), .extTrip(ext),
        .closeCmd(closeCmd), .manClose(manClose), .slow(slow), .auxFault(auxFault), .aux(aux));
    ////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // reference combiner: two or more phases in any mix of sources trip all three
    function automatic logic [4:0] combExp(input logic [8:0] r);
        logic [2:0] p;
        p = r[8:6] | r[5:3] | r[2:0];
        return ($countones(p) > 1) ? 5'h1e : {p, 2'h0};
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cko(input string nm, input logic [4:0] e);
        chk(nm, {27'h0, e}, {27'h0, tripPole, tripThreePole, closeCmd});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wt(input logic sel, input int lim, output int n);
        n = 0;
        while ((sel ? tripThreePole : closeCmd) !== 1'b1 && n < lim)
        begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic pulseClose;
        manClose <= 1'b1;
        tick(1);
        manClose <= 1'b0;
        tick(3);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int t;
        t = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk);
            t++;
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid && t < 50);
        chk("bresp", {29'h0, 1'b1, e}, {29'h0, bvalid, bresp});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int t;
        t = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk);
            t++;
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid && t < 50);
        chk("rdata", d, rdata);
        chk("rresp", {29'h0, 1'b1, e}, {29'h0, rvalid, rresp});
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        tick(5000);
        num_errors++;
        print_verdict();
    end
    initial
    begin
        {rst_n, awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        {tripReq, ext, recloseBlock, finalTrip, lineVoltage, manClose, slow, auxFault} = '0;
        seed = 32'h6d32e2ec;
        tick(6);
        rst_n <= 1'b1;
        tick(1);
        rd(8'h00, 32'h0, 2'h0);
        rd(8'h04, 32'h400, 2'h0);
        rd(8'h08, 32'h1, 2'h0);
        rd(8'h0c, 32'h0, 2'h2);
        wr(8'h08, 32'h1, 2'h2);
        wr(8'h00, 32'hffffffe0, 2'h0);
        rd(8'h00, 32'h0, 2'h0);
        for (int i = 0; i < 19; i++)
        begin
            seed = lfsr(seed);
            tripReq <= (i == 0) ? 9'h00a : (i == 1) ? 9'h050 : seed[8:0];
            slow <= seed[9];
            tick(2);
            cko("combiner", combExp(tripReq));
        end
        tripReq <= '0;
        slow <= 1'b0;
        pulseClose();
        ext <= 3'h1;
        tick(2);
        cko("ext trip", 5'h0);
        ext <= 3'h0;
        wr(8'h00, 32'h10, 2'h0);
        tick(3);
        cko("only3p off", 5'h0);
        auxFault <= 1'b1;
        tick(3);
        cko("aux off", 5'h0);
        auxFault <= 1'b0;
        pulseClose();
        wr(8'h00, 32'h12, 2'h0);
        ext <= 3'h2;
        tick(1);
        ext <= 3'h0;
        tick(2);
        cko("only3p", 5'h1e);
        tick(4);
        cko("forced clear", 5'h0);
        pulseClose();
        wr(8'h00, 32'h02, 2'h0);
        auxFault <= 1'b1;
        tick(2);
        cko("implausible", 5'h1e);
        auxFault <= 1'b0;
        tick(4);
        pulseClose();
        wr(8'h04, 32'd40, 2'h0);
        wr(8'h00, 32'h03, 2'h0);
        tripReq <= 9'h040;
        tick(2);
        cko("single pole", 5'h04);
        tripReq <= '0;
        tick(3);
        recloseBlock <= 1'b1;
        tick(2);
        cko("blocked", 5'h1e);
        recloseBlock <= 1'b0;
        tick(6);
        pulseClose();
        wr(8'h00, 32'h07, 2'h0);
        lineVoltage <= 1'b1;
        tripReq <= 9'h040;
        tick(2);
        tripReq <= '0;
        wt(1'b1, 80, c);
        chk("dead line trip", 32'h1, {31'h0, c < 80});
        wt(1'b0, 60, c);
        chk("dead line close", 32'd60, c);
        lineVoltage <= 1'b0;
        pulseClose();
        wr(8'h00, 32'h05, 2'h0);
        tripReq <= 9'h040;
        tick(2);
        tripReq <= '0;
        wt(1'b0, 100, c);
        chk("dead time", 32'h1, {31'h0, c >= 38 && c < 100});
        tick(4);
        wr(8'h00, 32'h09, 2'h0);
        tripReq <= 9'h040;
        tick(2);
        tripReq <= '0;
        repeat (2)
        begin
            lineVoltage <= 1'b1;
            tick(5);
            lineVoltage <= 1'b0;
            tick(5);
        end
        cko("no healthy volt", 5'h0);
        lineVoltage <= 1'b1;
        wt(1'b0, 100, c);
        chk("confirm", 32'h1, {31'h0, c >= 10 && c <= 14});
        lineVoltage <= 1'b0;
        tick(4);
        tripReq <= 9'h040;
        tick(2);
        tripReq <= '0;
        finalTrip <= 1'b1;
        tick(3);
        finalTrip <= 1'b0;
        lineVoltage <= 1'b1;
        wt(1'b0, 40, c);
        chk("final trip", 32'd40, c);
        print_verdict();
    end
endmodule
